// ==== hw/cpu_operand_pkg.sv ====
// Package of constants and types for the CPU operand and status logic
package cpu_operand_pkg;
    localparam logic [3:0] REG_PC = 4'h0;
    localparam logic [3:0] REG_SP = 4'h1;
    localparam logic [3:0] REG_SR = 4'h2;
    localparam logic [3:0] REG_CG = 4'h3;
    localparam logic [3:0] REG_GP_FIRST = 4'h4;
    // Status register bit positions
    localparam int BIT_C = 0;
    localparam int BIT_Z = 1;
    localparam int BIT_N = 2;
    localparam int BIT_GIE = 3;
    localparam int BIT_HALT = 4;
    localparam int BIT_XOFF = 5;
    localparam int BIT_GEN = 6;
    localparam int BIT_SMOFF = 7;
    localparam int BIT_V = 8;
    localparam logic [15:0] SR_IMPL_MASK = 16'h01ff;
    localparam logic [15:0] SR_RESET = 16'h0000;
    localparam logic [15:0] REG_RESET = 16'h0000;
    localparam logic [15:0] CONST_0 = 16'h0000;
    localparam logic [15:0] CONST_1 = 16'h0001;
    localparam logic [15:0] CONST_2 = 16'h0002;
    localparam logic [15:0] CONST_4 = 16'h0004;
    localparam logic [15:0] CONST_8 = 16'h0008;
    localparam logic [15:0] CONST_M1 = 16'hffff;
    localparam logic [15:0] BYTE_MASK = 16'h00ff;
    localparam logic [15:0] PC_ALIGN = 16'hfffe;
    localparam logic [15:0] STEP_BYTE = 16'h0001;
    localparam logic [15:0] STEP_WORD = 16'h0002;
    localparam logic [1:0] AS_REG = 2'h0;
    localparam logic [1:0] AS_IDX = 2'h1;
    localparam logic [1:0] AS_IND = 2'h2;
    localparam logic [1:0] AS_INC = 2'h3;
    localparam logic [1:0] SEL_MAIN_CTRL = 2'h1;
    localparam logic [1:0] SEL_CRYSTAL = 2'h2;
    typedef enum logic [3:0] {
        ALU_MOV = 4'h0, ALU_ADD = 4'h1, ALU_ADDC = 4'h2, ALU_SUB = 4'h3,
        ALU_SUBC = 4'h4, ALU_CMP = 4'h5, ALU_AND = 4'h6, ALU_XOR = 4'h7
    } alu_op_t;
    typedef enum logic [6:0] {
        SRC_REGISTER = 7'h01, SRC_INDEXED = 7'h02, SRC_SYMBOLIC = 7'h04, SRC_ABSOLUTE = 7'h08,
        SRC_INDIRECT = 7'h10, SRC_AUTOINC = 7'h20, SRC_IMMEDIATE = 7'h40
    } src_mode_t;
    typedef enum logic [3:0] {
        DST_REGISTER = 4'h1, DST_INDEXED = 4'h2, DST_SYMBOLIC = 4'h4, DST_ABSOLUTE = 4'h8
    } dst_mode_t;
    typedef enum logic [2:0] {
        ST_IDLE = 3'h1, ST_WRITE = 3'h2, ST_HALTED = 3'h4
    } exec_state_t;
endpackage

// ==== hw/cpu_operand_status_logic.sv ====
// Operand fetch, register file, status flags and low-power controls
`timescale 1ns/1ps
module cpu_operand_status_logic
    import cpu_operand_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Instruction fields, one instruction per issue pulse
    input wire logic issue,
    input wire alu_op_t alu_op,
    input wire logic is_byte,
    input wire logic [3:0] src_reg,
    input wire logic [1:0] source_mode_field,
    input wire logic [3:0] dst_reg,
    input wire logic dst_mode_field,
    input wire logic [15:0] src_ext_word,
    input wire logic [15:0] dst_ext_word,
    input wire logic [15:0] src_mem_data,
    input wire logic [15:0] dst_mem_data,
    // Wake-up from an interrupt clears the halt bit
    input wire logic wake,
    // Clock routing seen by the oscillator controls
    input wire logic [1:0] main_clock_source,
    input wire logic [1:0] submain_clock_source,
    // Maskable interrupt request in
    input wire logic irq_request,
    // Operand results
    output logic [15:0] src_operand,
    output logic [15:0] src_address,
    output logic [15:0] dst_address,
    output logic [15:0] result,
    output logic result_valid,
    output src_mode_t src_mode,
    output dst_mode_t dst_mode,
    // Program counter and status
    output logic [15:0] program_counter,
    output logic [15:0] cpu_status_flags,
    // Low-power controls
    output logic submain_clock_stop,
    output logic controlled_oscillator_dc_off,
    output logic low_freq_crystal_oscillator_stop,
    output logic cpu_halted,
    output logic irq_accept
);
    // ==========================================================
    // Decode
    src_mode_t dec_src_mode;
    dst_mode_t dec_dst_mode;
    logic src_is_const;
    logic [15:0] const_value;
    logic needs_ext_src;
    logic needs_ext_dst;
    logic [15:0] autoinc_step;

    operand_mode_decoder u_decoder (
        .src_reg(src_reg),
        .source_mode_field(source_mode_field),
        .is_byte(is_byte),
        .dst_reg(dst_reg),
        .dst_mode_field(dst_mode_field),
        .src_mode(dec_src_mode),
        .dst_mode(dec_dst_mode),
        .src_is_const(src_is_const),
        .const_value(const_value),
        .needs_ext_src(needs_ext_src),
        .needs_ext_dst(needs_ext_dst),
        .autoinc_step(autoinc_step)
    );

    // ==========================================================
    // Helper functions
    function automatic logic [15:0] width_mask(input logic [15:0] value, input logic byte_op);
        width_mask = byte_op ? (value & BYTE_MASK) : value;
    endfunction

    function automatic logic sign_of(input logic [15:0] value, input logic byte_op);
        sign_of = byte_op ? value[7] : value[15];
    endfunction

    // ==========================================================
    // State
    logic [15:0] regs [0:15];
    logic [15:0] next_regs [0:15];
    logic [15:0] next_sr;
    logic [15:0] next_src_operand;
    logic [15:0] next_src_address;
    logic [15:0] next_dst_address;
    logic [15:0] next_result;
    logic next_result_valid;
    exec_state_t state;
    exec_state_t next_state;
    src_mode_t next_src_mode;
    dst_mode_t next_dst_mode;

    // Combinational datapath terms
    logic [15:0] src_val;
    logic [15:0] dst_val;
    logic [15:0] b_val;
    logic [16:0] sum;
    logic carry_in;
    logic carry_out;
    logic is_add;
    logic is_sub;
    logic arith;
    logic [15:0] alu_res;
    logic sa;
    logic sb;
    logic sr_res;
    logic writes_dst;
    logic [15:0] pc_step;

    always_comb begin
        // Operand selection
        if (src_is_const) begin
            src_val = const_value;
        end else if (dec_src_mode == SRC_REGISTER) begin
            src_val = regs[src_reg];
        end else if (dec_src_mode == SRC_IMMEDIATE) begin
            src_val = src_ext_word;
        end else begin
            src_val = src_mem_data;
        end
        src_val = width_mask(src_val, is_byte);
        dst_val = width_mask(dst_mode_field ? dst_mem_data : regs[dst_reg], is_byte);
        is_add = (alu_op == ALU_ADD) || (alu_op == ALU_ADDC);
        is_sub = (alu_op == ALU_SUB) || (alu_op == ALU_SUBC) || (alu_op == ALU_CMP);
        arith = is_add || is_sub;
        // Subtraction is dst + not(src) + 1, carry means no borrow
        b_val = width_mask(is_sub ? ~src_val : src_val, is_byte);
        if (alu_op == ALU_ADDC || alu_op == ALU_SUBC) begin
            carry_in = regs[REG_SR][BIT_C];
        end else begin
            carry_in = (alu_op == ALU_SUB) || (alu_op == ALU_CMP);
        end
        sum = {1'b0, dst_val} + {1'b0, b_val} + {16'h0000, carry_in};
        carry_out = is_byte ? sum[8] : sum[16];
        case (alu_op)
            ALU_MOV: alu_res = src_val;
            ALU_AND: alu_res = src_val & dst_val;
            ALU_XOR: alu_res = src_val ^ dst_val;
            default: alu_res = sum[15:0];
        endcase
        alu_res = width_mask(alu_res, is_byte);
        sa = sign_of(dst_val, is_byte);
        sb = sign_of(src_val, is_byte);
        sr_res = sign_of(alu_res, is_byte);
        writes_dst = (alu_op != ALU_CMP);
        pc_step = STEP_WORD + (needs_ext_src ? STEP_WORD : CONST_0)
            + (needs_ext_dst ? STEP_WORD : CONST_0);
    end

    always_comb begin
        for (int i = 0; i < 16; i++) begin
            next_regs[i] = regs[i];
        end
        next_state = state;
        next_src_operand = src_operand;
        next_src_address = src_address;
        next_dst_address = dst_address;
        next_result = result;
        next_result_valid = 1'b0;
        next_src_mode = src_mode;
        next_dst_mode = dst_mode;
        next_sr = regs[REG_SR];
        if (wake) begin
            next_sr[BIT_HALT] = 1'b0;
        end
        case (state)
            ST_IDLE: begin
                if (regs[REG_SR][BIT_HALT] && !wake) begin
                    next_state = ST_HALTED;
                end else if (issue) begin
                    next_state = ST_WRITE;
                    next_src_mode = dec_src_mode;
                    next_dst_mode = dec_dst_mode;
                    next_src_operand = src_val;
                    next_result = alu_res;
                    next_result_valid = 1'b1;
                    // Address generation
                    case (dec_src_mode)
                        SRC_INDEXED, SRC_SYMBOLIC: next_src_address = regs[src_reg] + src_ext_word;
                        SRC_ABSOLUTE: next_src_address = src_ext_word;
                        SRC_INDIRECT, SRC_AUTOINC: next_src_address = regs[src_reg];
                        SRC_IMMEDIATE: next_src_address = regs[REG_PC] + STEP_WORD;
                        default: next_src_address = CONST_0;
                    endcase
                    case (dec_dst_mode)
                        DST_ABSOLUTE: next_dst_address = dst_ext_word;
                        DST_REGISTER: next_dst_address = CONST_0;
                        default: next_dst_address = regs[dst_reg] + dst_ext_word;
                    endcase
                    next_regs[REG_PC] = (regs[REG_PC] + pc_step) & PC_ALIGN;
                    if (dec_src_mode == SRC_AUTOINC && !src_is_const) begin
                        next_regs[src_reg] = regs[src_reg] + autoinc_step;
                    end
                    // Flags, both widths follow the masked result
                    if (alu_op != ALU_MOV) begin
                        next_sr[BIT_N] = sr_res;
                        next_sr[BIT_Z] = (alu_res == CONST_0);
                        next_sr[BIT_C] = arith ? carry_out : (alu_res != CONST_0);
                        if (is_add) begin
                            next_sr[BIT_V] = (sa == sb) && (sr_res != sa);
                        end else if (is_sub) begin
                            next_sr[BIT_V] = (sa != sb) && (sr_res != sa);
                        end else begin
                            next_sr[BIT_V] = 1'b0;
                        end
                    end
                    // Register-mode write back; R3 never written, R2 written by word operations only
                    if (writes_dst && !dst_mode_field && dst_reg != REG_CG) begin
                        if (dst_reg == REG_SR) begin
                            if (!is_byte) begin
                                next_sr = alu_res & SR_IMPL_MASK;
                            end
                        end else if (dst_reg == REG_PC) begin
                            next_regs[REG_PC] = alu_res & PC_ALIGN;
                        end else begin
                            next_regs[dst_reg] = alu_res;
                        end
                    end
                end
            end
            ST_WRITE: next_state = ST_IDLE;
            ST_HALTED: begin
                if (!regs[REG_SR][BIT_HALT] || wake) begin
                    next_state = ST_IDLE;
                end
            end
            default: next_state = ST_IDLE;
        endcase
        next_regs[REG_SR] = next_sr;
        next_regs[REG_CG] = CONST_0;
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            for (int i = 0; i < 16; i++) begin
                regs[i] <= REG_RESET;
            end
            state <= ST_IDLE;
            src_operand <= CONST_0;
            src_address <= CONST_0;
            dst_address <= CONST_0;
            result <= CONST_0;
            result_valid <= 1'b0;
            src_mode <= SRC_REGISTER;
            dst_mode <= DST_REGISTER;
        end else begin
            for (int i = 0; i < 16; i++) begin
                regs[i] <= next_regs[i];
            end
            state <= next_state;
            src_operand <= next_src_operand;
            src_address <= next_src_address;
            dst_address <= next_dst_address;
            result <= next_result;
            result_valid <= next_result_valid;
            src_mode <= next_src_mode;
            dst_mode <= next_dst_mode;
        end
    end

    // ==========================================================
    // Status outputs and low-power controls
    always_comb begin
        program_counter = regs[REG_PC];
        cpu_status_flags = regs[REG_SR];
        submain_clock_stop = regs[REG_SR][BIT_SMOFF];
        controlled_oscillator_dc_off = regs[REG_SR][BIT_GEN] && main_clock_source != SEL_MAIN_CTRL
            && submain_clock_source != SEL_MAIN_CTRL;
        low_freq_crystal_oscillator_stop = regs[REG_SR][BIT_XOFF] && main_clock_source != SEL_CRYSTAL
            && submain_clock_source != SEL_CRYSTAL;
        cpu_halted = regs[REG_SR][BIT_HALT];
        irq_accept = irq_request && regs[REG_SR][BIT_GIE];
    end

    // ==========================================================
    // Checks
    AST_SUBMAIN: assert property (@(posedge clock) disable iff (rst)
        submain_clock_stop == cpu_status_flags[BIT_SMOFF]) else $error("submain stop mismatch");
    AST_GEN_OFF: assert property (@(posedge clock) disable iff (rst)
        controlled_oscillator_dc_off |-> cpu_status_flags[BIT_GEN] && main_clock_source != SEL_MAIN_CTRL
        && submain_clock_source != SEL_MAIN_CTRL) else $error("generator off while in use");
    AST_XTAL_OFF: assert property (@(posedge clock) disable iff (rst)
        low_freq_crystal_oscillator_stop |-> cpu_status_flags[BIT_XOFF] && main_clock_source != SEL_CRYSTAL
        && submain_clock_source != SEL_CRYSTAL) else $error("crystal off while in use");
    AST_IRQ: assert property (@(posedge clock) disable iff (rst)
        irq_accept |-> irq_request && cpu_status_flags[BIT_GIE]) else $error("irq passed while masked");
    AST_PC_EVEN: assert property (@(posedge clock) disable iff (rst)
        program_counter[0] == 1'b0) else $error("program counter odd");
    AST_ZERO: assert property (@(posedge clock) disable iff (rst)
        issue && state == ST_IDLE && !cpu_halted && !wake && alu_op == ALU_ADD && dst_reg != REG_SR
        |=> cpu_status_flags[BIT_Z] == (result == CONST_0)) else $error("zero flag wrong");
    AST_BYTE_HI: assert property (@(posedge clock) disable iff (rst)
        issue && state == ST_IDLE && !cpu_halted && is_byte |=> result[15:8] == 8'h00)
        else $error("byte result upper byte set");
    AST_CONST_R3: assert property (@(posedge clock) disable iff (rst)
        issue && state == ST_IDLE && !cpu_halted && !wake && src_reg == REG_CG && source_mode_field == AS_INC
        && !is_byte |=> src_operand == CONST_M1) else $error("r3 constant wrong");
    AST_HALT: assert property (@(posedge clock) disable iff (rst)
        state == ST_HALTED |-> !result_valid) else $error("work while halted");
    COV_ADD: cover property (@(posedge clock) result_valid && cpu_status_flags[BIT_V]);
    COV_HALT: cover property (@(posedge clock) state == ST_HALTED);
    COV_IMM: cover property (@(posedge clock) result_valid && src_mode == SRC_IMMEDIATE);
endmodule

// ==== hw/operand_mode_decoder.sv ====
// Addressing-mode and constant-generator decode
`timescale 1ns/1ps
module operand_mode_decoder
    import cpu_operand_pkg::*;
(
    // Source field
    input wire logic [3:0] src_reg,
    input wire logic [1:0] source_mode_field,
    input wire logic is_byte,
    // Destination field
    input wire logic [3:0] dst_reg,
    input wire logic dst_mode_field,
    // Decode results
    output src_mode_t src_mode,
    output dst_mode_t dst_mode,
    output logic src_is_const,
    output logic [15:0] const_value,
    output logic needs_ext_src,
    output logic needs_ext_dst,
    output logic [15:0] autoinc_step
);
    always_comb begin
        src_is_const = 1'b0;
        const_value = CONST_0;
        src_mode = SRC_REGISTER;
        if (src_reg == REG_CG) begin
            src_is_const = 1'b1;
            case (source_mode_field)
                AS_REG: const_value = CONST_0;
                AS_IDX: const_value = CONST_1;
                AS_IND: const_value = CONST_2;
                default: const_value = CONST_M1;
            endcase
        end else if (src_reg == REG_SR && source_mode_field[1]) begin
            src_is_const = 1'b1;
            const_value = source_mode_field[0] ? CONST_8 : CONST_4;
        end else if (src_reg == REG_SR && source_mode_field == AS_REG && is_byte) begin
            // Byte access to the status register falls back to the generator
            src_is_const = 1'b1;
            const_value = CONST_0;
        end
        case (source_mode_field)
            AS_REG: src_mode = SRC_REGISTER;
            AS_IDX: begin
                if (src_reg == REG_PC) begin
                    src_mode = SRC_SYMBOLIC;
                end else if (src_reg == REG_SR) begin
                    src_mode = SRC_ABSOLUTE;
                end else begin
                    src_mode = SRC_INDEXED;
                end
            end
            AS_IND: src_mode = SRC_INDIRECT;
            default: src_mode = (src_reg == REG_PC) ? SRC_IMMEDIATE : SRC_AUTOINC;
        endcase
        if (!dst_mode_field) begin
            dst_mode = DST_REGISTER;
        end else if (dst_reg == REG_PC) begin
            dst_mode = DST_SYMBOLIC;
        end else if (dst_reg == REG_SR) begin
            dst_mode = DST_ABSOLUTE;
        end else begin
            dst_mode = DST_INDEXED;
        end
        needs_ext_src = !(src_reg == REG_CG || (src_reg == REG_SR && source_mode_field[1]))
            && (source_mode_field == AS_IDX || (src_reg == REG_PC && source_mode_field == AS_INC));
        needs_ext_dst = dst_mode_field;
        autoinc_step = (is_byte && src_reg != REG_PC) ? STEP_BYTE : STEP_WORD;
    end
endmodule

// ==== test/testbench.sv ====
// Self-checking bench for the operand decode, status flags and low-power controls
`timescale 1ns/1ps
module testbench;
    import cpu_operand_pkg::*;
    logic clock = 1'b0, rst = 1'b1, issue = 1'b0, is_byte = 1'b0, dst_mode_field = 1'b0, wake = 1'b0;
    logic irq_request = 1'b0;
    alu_op_t alu_op = ALU_MOV;
    logic [3:0] src_reg = 4'h0, dst_reg = 4'h0;
    logic [1:0] source_mode_field = 2'h0, main_clock_source = 2'h0, submain_clock_source = 2'h0;
    logic [15:0] src_ext_word = 16'h0, dst_ext_word = 16'h0, src_mem_data = 16'h0, dst_mem_data = 16'h0;
    logic [15:0] src_operand, src_address, dst_address, result, program_counter, cpu_status_flags;
    logic result_valid, submain_clock_stop, controlled_oscillator_dc_off, low_freq_crystal_oscillator_stop;
    logic cpu_halted, irq_accept;
    src_mode_t src_mode;
    dst_mode_t dst_mode;
    int failures = 0, n_compared = 0, cycles = 0;
    logic [31:0] seed = 32'hf580;
    logic [15:0] sr_exp = 16'h0, pc_exp = 16'h0, a, b;
    logic [19:0] e;
    logic by;
    alu_op_t op;
    alu_op_t ops [5] = '{ALU_ADD, ALU_ADDC, ALU_SUB, ALU_SUBC, ALU_CMP};
    logic [15:0] cv [6] = '{CONST_4, CONST_8, CONST_0, CONST_1, CONST_2, CONST_M1};

    cpu_operand_status_logic uut (.clock, .rst, .issue, .alu_op, .is_byte, .src_reg, .source_mode_field,
        .dst_reg, .dst_mode_field, .src_ext_word, .dst_ext_word, .src_mem_data, .dst_mem_data, .wake,
        .main_clock_source, .submain_clock_source, .irq_request, .src_operand, .src_address, .dst_address,
        .result, .result_valid, .src_mode, .dst_mode, .program_counter, .cpu_status_flags,
        .submain_clock_stop, .controlled_oscillator_dc_off, .low_freq_crystal_oscillator_stop,
        .cpu_halted, .irq_accept);

    // ==========
    // Clock, timeout, reporting
    always #12.5 clock = ~clock;
    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        $display("compared %0d, mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    function automatic logic [31:0] lfsr(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Expected {V, N, Z, C, result}; subtract is add of the inverted source plus carry
    function automatic logic [19:0] alu(alu_op_t o, logic [15:0] s, logic [15:0] d, logic bw, logic cin);
        logic [16:0] t;
        logic [15:0] m, x, y, r;
        logic sub, n, c;
        m = bw ? BYTE_MASK : 16'hffff;
        sub = o inside {ALU_SUB, ALU_SUBC, ALU_CMP};
        x = d & m;
        y = (sub ? ~s : s) & m;
        t = x + y + ((o == ALU_ADD) ? 17'h0 : (o == ALU_SUBC || o == ALU_ADDC) ? {16'h0, cin} : 17'h1);
        r = t[15:0] & m;
        c = bw ? t[8] : t[16];
        n = bw ? r[7] : r[15];
        return {((bw ? x[7] : x[15]) == (bw ? y[7] : y[15])) && (n != (bw ? x[7] : x[15])), n, r == 16'h0, c, r};
    endfunction

    // One accepted instruction; PC model steps past every extension word
    task automatic exec(alu_op_t o, logic bw, logic [3:0] sr, logic [1:0] sm, logic [3:0] dr, logic dm,
            logic [15:0] se);
        int i;
        @(negedge clock);
        alu_op = o;
        is_byte = bw;
        src_reg = sr;
        source_mode_field = sm;
        dst_reg = dr;
        dst_mode_field = dm;
        src_ext_word = se;
        seed = lfsr(seed);
        dst_ext_word = seed[31:16];
        src_mem_data = seed[15:0];
        issue = 1'b1;
        @(negedge clock);
        issue = 1'b0;
        for (i = 0; i < 4 && result_valid !== 1'b1; i++)
            @(negedge clock);
        check("result_valid", {15'h0, result_valid}, 16'h1);
        pc_exp += 16'h2 + (((sm == AS_IDX && sr != REG_CG) || (sm == AS_INC && sr == REG_PC)) ? 16'h2 : 16'h0);
        pc_exp += dm ? 16'h2 : 16'h0;
        check("program_counter", program_counter, pc_exp);
        // Let the write cycle pass; an issue there would be refused
        @(negedge clock);
    endtask

    // ==========
    // Main sequence
    initial begin
        repeat (20) @(negedge clock);
        rst = 1'b0;
        check("status after reset", cpu_status_flags, SR_RESET);
        for (int k = 0; k < 6; k++) begin
            exec(ALU_MOV, 1'b0, (k < 2) ? REG_SR : REG_CG, (k < 2) ? 2'(k + 2) : 2'(k - 2), 4'h5, 1'b0, 16'h0);
            check("constant", src_operand, cv[k]);
        end
        exec(ALU_MOV, 1'b1, REG_SR, AS_REG, 4'h5, 1'b0, 16'h0);
        check("byte status source", src_operand, CONST_0);
        exec(ALU_MOV, 1'b0, REG_PC, AS_INC, REG_CG, 1'b0, 16'h5a5a);
        exec(ALU_MOV, 1'b0, REG_CG, AS_REG, 4'h5, 1'b0, 16'h0);
        check("r3 after write", src_operand, CONST_0);
        $display("constant generator test done");
        for (int i = 0; i < 40; i++) begin
            seed = lfsr(seed);
            a = seed[15:0];
            b = seed[31:16];
            op = ops[seed[18:16] % 5];
            by = seed[20];
            if (i < 2) begin
                a = i ? 16'h8000 : 16'h7fff;
                b = 16'h0001;
                op = i ? ALU_SUB : ALU_ADD;
                by = 1'b0;
            end
            exec(ALU_MOV, 1'b0, REG_PC, AS_INC, 4'h4, 1'b0, a);
            check("immediate mode", {9'h0, src_mode}, {9'h0, SRC_IMMEDIATE});
            e = alu(op, b, a, by, sr_exp[BIT_C]);
            exec(op, by, REG_PC, AS_INC, 4'h4, 1'b0, b);
            {sr_exp[BIT_V], sr_exp[BIT_N], sr_exp[BIT_Z], sr_exp[BIT_C]} = e[19:16];
            check("flags", cpu_status_flags, sr_exp);
            if (op != ALU_CMP)
                check("result", result, e[15:0]);
        end
        $display("arithmetic flag test done");
        exec(ALU_MOV, 1'b0, REG_PC, AS_INC, 4'h4, 1'b0, 16'h1234);
        exec(ALU_MOV, 1'b0, 4'h4, AS_IDX, REG_SR, 1'b1, 16'h0010);
        check("indexed address", src_address, 16'h1244);
        check("absolute dst address", dst_address, dst_ext_word);
        check("dst mode", {12'h0, dst_mode}, {12'h0, DST_ABSOLUTE});
        exec(ALU_MOV, 1'b0, REG_SR, AS_IDX, 4'h5, 1'b0, 16'h0200);
        check("absolute address", src_address, 16'h0200);
        exec(ALU_MOV, 1'b0, REG_PC, AS_IDX, 4'h5, 1'b0, 16'h0040);
        check("symbolic mode", {9'h0, src_mode}, {9'h0, SRC_SYMBOLIC});
        exec(ALU_MOV, 1'b0, 4'h4, AS_IND, 4'h5, 1'b0, 16'h0);
        check("indirect operand", src_operand, src_mem_data);
        exec(ALU_MOV, 1'b0, 4'h4, AS_REG, 4'h6, 1'b1, 16'h0);
        check("dst indexed mode", {12'h0, dst_mode}, {12'h0, DST_INDEXED});
        check("dst indexed address", dst_address, dst_ext_word);
        a = 16'h1234;
        for (int w = 0; w < 2; w++) begin
            exec(ALU_MOV, w == 0, 4'h4, AS_INC, 4'h5, 1'b0, 16'h0);
            check("autoinc address", src_address, a);
            a += w ? STEP_WORD : STEP_BYTE;
            exec(ALU_MOV, 1'b0, 4'h4, AS_REG, 4'h5, 1'b0, 16'h0);
            check("pointer after step", src_operand, a);
        end
        $display("addressing test done");
        exec(ALU_MOV, 1'b0, REG_PC, AS_INC, REG_SR, 1'b0, 16'h00e9);
        sr_exp = 16'h00e9;
        check("status write", cpu_status_flags, sr_exp);
        for (int k = 0; k < 32; k++) begin
            @(negedge clock);
            {irq_request, main_clock_source, submain_clock_source} = 5'(k);
            #1;
            check("submain stop", {15'h0, submain_clock_stop}, 16'h1);
            check("dc off", {15'h0, controlled_oscillator_dc_off},
                {15'h0, main_clock_source != 2'h1 && submain_clock_source != 2'h1});
            check("crystal stop", {15'h0, low_freq_crystal_oscillator_stop},
                {15'h0, main_clock_source != 2'h2 && submain_clock_source != 2'h2});
            check("irq accept", {15'h0, irq_accept}, {15'h0, irq_request});
        end
        exec(ALU_MOV, 1'b0, REG_PC, AS_INC, REG_SR, 1'b0, 16'h0010);
        check("halted", {15'h0, cpu_halted}, 16'h1);
        check("irq masked", {15'h0, irq_accept}, 16'h0);
        @(negedge clock);
        issue = 1'b1;
        @(negedge clock);
        issue = 1'b0;
        check("halted refuses", {15'h0, result_valid}, 16'h0);
        repeat (2) @(negedge clock);
        check("halted pc", program_counter, pc_exp);
        wake = 1'b1;
        @(negedge clock);
        wake = 1'b0;
        @(negedge clock);
        check("woken", {15'h0, cpu_halted}, 16'h0);
        $display("low-power test done");
        print_verdict();
    end
endmodule
